// File: rtl/bof_datapath.sv
// Bit and flag execution datapath with an Avalon-MM register slave.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module bof_datapath #(
   // Operand width and bit-select width; the logic serves only 8 and 3.
   parameter int unsigned DATA_W = 8,
   parameter int unsigned SEL_W = 3
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Avalon-MM slave.
   input wire bof_pkg::bof_av_req_t av_req,
   output bof_pkg::bof_av_rsp_t av_rsp,
   // Execution state seen by the core.
   output logic [7:0] status_word,
   output logic [7:0] io_reg,
   output logic busy
);
   bof_pkg::bof_state_t state_ff;
   bof_pkg::bof_state_t nxt_state;
   logic [7:0] status_ff;
   logic [7:0] operand_ff;
   logic [7:0] result_ff;
   logic [7:0] io_ff;
   logic [3:0] cycles_ff;
   logic [3:0] wait_ff;
   logic [15:0] ctrl_ff;
   logic [7:0] nxt_result;
   logic [7:0] nxt_status;
   logic [7:0] nxt_io;
   logic [3:0] nxt_cycles;
   logic [31:0] rdata_ff;
   logic rvalid_ff;
   logic ctrl_wr;
   logic [4:0] op_code;
   logic [2:0] sel;
   logic in_sram;
   logic in_ext;
   logic [7:0] d;
   logic idle_wr;

   // The datapath is written for one byte and a 3-bit select only.
   if ((DATA_W != 8) || (SEL_W != 3)) begin : g_width_check
      $error("bof_datapath serves DATA_W 8 and SEL_W 3 only");
   end

   // A control write launches the operation; the slave stalls while busy
   // so that a second launch cannot overlap the multi-cycle variants.
   assign ctrl_wr = av_req.write && (av_req.address == bof_pkg::ADDR_CTRL)
      && (state_ff == bof_pkg::ST_IDLE);
   assign op_code = av_req.writedata[bof_pkg::CTRL_OP_LSB +: 5];
   assign sel = av_req.writedata[bof_pkg::CTRL_SEL_LSB +: 3];
   assign in_sram = av_req.writedata[bof_pkg::CTRL_SRAM_BIT];
   assign in_ext = av_req.writedata[bof_pkg::CTRL_EXT_BIT];
   assign d = operand_ff;
   assign idle_wr = av_req.write && (state_ff == bof_pkg::ST_IDLE);

   // Result and flags of the launched opcode.
   always_comb begin
      nxt_result = d;
      nxt_status = status_ff;
      nxt_io = io_ff;
      case (op_code)
         bof_pkg::OP_ROTATE_LEFT_CARRY: begin
            nxt_result = {d[6:0], status_ff[bof_pkg::SW_C]};
            nxt_status[bof_pkg::SW_C] = d[7];
            nxt_status[bof_pkg::SW_H] = d[3];
            nxt_status[bof_pkg::SW_N] = d[6];
            nxt_status[bof_pkg::SW_V] = d[6] ^ d[7];
            nxt_status[bof_pkg::SW_Z] = ({d[6:0], status_ff[0]} == 8'h00);
            nxt_status[bof_pkg::SW_S] = d[6] ^ (d[6] ^ d[7]);
         end
         bof_pkg::OP_ROTATE_RIGHT_CARRY: begin
            nxt_result = {status_ff[bof_pkg::SW_C], d[7:1]};
            nxt_status[bof_pkg::SW_C] = d[0];
            nxt_status[bof_pkg::SW_N] = status_ff[bof_pkg::SW_C];
            nxt_status[bof_pkg::SW_V] = status_ff[bof_pkg::SW_C] ^ d[0];
            nxt_status[bof_pkg::SW_Z] = ({status_ff[0], d[7:1]} == 8'h00);
            nxt_status[bof_pkg::SW_S] = d[0];
         end
         bof_pkg::OP_ARITH_SHIFT_RIGHT: begin
            nxt_result = {d[7], d[7:1]};
            nxt_status[bof_pkg::SW_C] = d[0];
            nxt_status[bof_pkg::SW_N] = d[7];
            nxt_status[bof_pkg::SW_V] = d[7] ^ d[0];
            nxt_status[bof_pkg::SW_Z] = ({d[7], d[7:1]} == 8'h00);
            nxt_status[bof_pkg::SW_S] = d[0];
         end
         bof_pkg::OP_SWAP: begin
            nxt_result = {d[3:0], d[7:4]};
         end
         bof_pkg::OP_FLAG_SET: begin
            nxt_status[sel] = 1'b1;
         end
         bof_pkg::OP_FLAG_CLEAR: begin
            nxt_status[sel] = 1'b0;
         end
         bof_pkg::OP_IO_BIT_SET: begin
            nxt_io[sel] = 1'b1;
         end
         bof_pkg::OP_IO_BIT_CLEAR: begin
            nxt_io[sel] = 1'b0;
         end
         bof_pkg::OP_BIT_TO_TRANSFER: begin
            nxt_status[bof_pkg::SW_T] = d[sel];
         end
         bof_pkg::OP_TRANSFER_TO_BIT: begin
            nxt_result[sel] = status_ff[bof_pkg::SW_T];
         end
         bof_pkg::OP_OVERFLOW_SET: begin
            nxt_status[bof_pkg::SW_V] = 1'b1;
         end
         bof_pkg::OP_OVERFLOW_CLEAR: begin
            nxt_status[bof_pkg::SW_V] = 1'b0;
         end
         bof_pkg::OP_HALF_CARRY_SET: begin
            nxt_status[bof_pkg::SW_H] = 1'b1;
         end
         bof_pkg::OP_HALF_CARRY_CLEAR: begin
            nxt_status[bof_pkg::SW_H] = 1'b0;
         end
         bof_pkg::OP_SIGNED_SET: begin
            nxt_status[bof_pkg::SW_S] = 1'b1;
         end
         bof_pkg::OP_SIGNED_CLEAR: begin
            nxt_status[bof_pkg::SW_S] = 1'b0;
         end
         default: begin
            nxt_result = d;
         end
      endcase
   end

   // Cycle cost of the launched opcode.
   // The external cost is a chosen figure; a slow external bus may need more.
   always_comb begin
      nxt_cycles = bof_pkg::BASE_CYCLES;
      if (in_sram) begin
         nxt_cycles = nxt_cycles + bof_pkg::SRAM_EXTRA_CYCLES;
      end
      if (in_ext) begin
         nxt_cycles = nxt_cycles + bof_pkg::EXT_EXTRA_CYCLES;
      end
   end

   // State update happens at the launch edge; the busy phase only stalls.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_ff <= bof_pkg::SW_RESET;
      end else if (ctrl_wr) begin
         status_ff <= nxt_status;
      end else if (idle_wr && (av_req.address == bof_pkg::ADDR_STATUS)) begin
         status_ff <= av_req.writedata[7:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         result_ff <= bof_pkg::REG_RESET;
      end else if (ctrl_wr) begin
         result_ff <= nxt_result;
      end
   end

   // A launch and a direct write cannot share a cycle: one address per beat.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         io_ff <= bof_pkg::IO_RESET;
      end else if (ctrl_wr) begin
         io_ff <= nxt_io;
      end else if (idle_wr && (av_req.address == bof_pkg::ADDR_IO)) begin
         io_ff <= av_req.writedata[7:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cycles_ff <= 4'h0;
      end else if (ctrl_wr) begin
         cycles_ff <= nxt_cycles;
      end
   end

   // The last control word is kept so that software can read back its launch.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_ff <= 16'h0000;
      end else if (ctrl_wr) begin
         ctrl_ff <= av_req.writedata[15:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         operand_ff <= bof_pkg::REG_RESET;
      end else if (av_req.write && (state_ff == bof_pkg::ST_IDLE)
         && (av_req.address == bof_pkg::ADDR_OPERAND)) begin
         operand_ff <= av_req.writedata[7:0];
      end else if (ctrl_wr) begin
         operand_ff <= nxt_result;
      end
   end

   // Extra cycles beyond the first hold the machine busy.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         bof_pkg::ST_IDLE: begin
            if (ctrl_wr && (nxt_cycles > bof_pkg::BASE_CYCLES)) begin
               nxt_state = bof_pkg::ST_BUSY;
            end
         end
         bof_pkg::ST_BUSY: begin
            if (wait_ff == 4'h1) begin
               nxt_state = bof_pkg::ST_IDLE;
            end
         end
         default: nxt_state = bof_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= bof_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // One-cycle opcodes load zero here, so the countdown never runs for them.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wait_ff <= 4'h0;
      end else if (ctrl_wr) begin
         wait_ff <= nxt_cycles - bof_pkg::BASE_CYCLES;
      end else if (wait_ff != 4'h0) begin
         wait_ff <= wait_ff - 4'h1;
      end
   end

   // Reads answer one cycle after the request; waitrequest covers the gap.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_ff <= bof_pkg::UNMAPPED_READ;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= av_req.read && !rvalid_ff;
         // Unmapped addresses read as zero so that software may probe safely.
         case (av_req.address)
            bof_pkg::ADDR_CTRL: begin
               rdata_ff <= {16'h0000, ctrl_ff};
            end
            bof_pkg::ADDR_OPERAND: begin
               rdata_ff <= {24'h00_0000, operand_ff};
            end
            bof_pkg::ADDR_STATUS: begin
               rdata_ff <= {24'h00_0000, status_ff};
            end
            bof_pkg::ADDR_RESULT: begin
               rdata_ff <= {24'h00_0000, result_ff};
            end
            bof_pkg::ADDR_IO: begin
               rdata_ff <= {24'h00_0000, io_ff};
            end
            bof_pkg::ADDR_CYCLES: begin
               rdata_ff <= {28'h000_0000, cycles_ff};
            end
            default: begin
               rdata_ff <= bof_pkg::UNMAPPED_READ;
            end
         endcase
      end
   end

   always_comb begin
      av_rsp.readdata = rdata_ff;
      av_rsp.waitrequest = (av_req.read && !rvalid_ff)
         || (av_req.write && (state_ff != bof_pkg::ST_IDLE));
   end

   assign status_word = status_ff;
   assign io_reg = io_ff;
   assign busy = (state_ff != bof_pkg::ST_IDLE);
endmodule
`default_nettype wire

// File: rtl/bof_pkg.sv
// Package with opcodes, status-word layout and bus constants for the bit datapath.
package bof_pkg;
   localparam int unsigned DATA_W = 8;
   // Status-word bit positions.
   localparam logic [2:0] SW_C = 3'h0;
   localparam logic [2:0] SW_Z = 3'h1;
   localparam logic [2:0] SW_N = 3'h2;
   localparam logic [2:0] SW_V = 3'h3;
   localparam logic [2:0] SW_S = 3'h4;
   localparam logic [2:0] SW_H = 3'h5;
   localparam logic [2:0] SW_T = 3'h6;
   localparam logic [2:0] SW_I = 3'h7;
   localparam logic [7:0] SW_RESET = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] IO_RESET = 8'h00;
   // Register map, byte addresses.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OPERAND = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0c;
   localparam logic [7:0] ADDR_IO = 8'h10;
   localparam logic [7:0] ADDR_CYCLES = 8'h14;
   // Control word fields.
   localparam int unsigned CTRL_OP_LSB = 0;
   localparam int unsigned CTRL_SEL_LSB = 8;
   localparam int unsigned CTRL_SRAM_BIT = 12;
   localparam int unsigned CTRL_EXT_BIT = 13;
   localparam logic [3:0] EXT_EXTRA_CYCLES = 4'h1;
   localparam logic [3:0] BASE_CYCLES = 4'h1;
   localparam logic [3:0] SRAM_EXTRA_CYCLES = 4'h1;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_ROTATE_LEFT_CARRY = 5'h01,
      OP_ROTATE_RIGHT_CARRY = 5'h02,
      OP_ARITH_SHIFT_RIGHT = 5'h03,
      OP_SWAP = 5'h04,
      OP_FLAG_SET = 5'h05,
      OP_FLAG_CLEAR = 5'h06,
      OP_IO_BIT_SET = 5'h07,
      OP_IO_BIT_CLEAR = 5'h08,
      OP_BIT_TO_TRANSFER = 5'h09,
      OP_TRANSFER_TO_BIT = 5'h0a,
      OP_OVERFLOW_SET = 5'h0b,
      OP_OVERFLOW_CLEAR = 5'h0c,
      OP_HALF_CARRY_SET = 5'h0d,
      OP_HALF_CARRY_CLEAR = 5'h0e,
      OP_SIGNED_SET = 5'h0f,
      OP_SIGNED_CLEAR = 5'h10
   } bof_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } bof_state_t;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } bof_av_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } bof_av_rsp_t;
endpackage

// File: verif/bof_datapath_sva.sv
// Concurrent checks on the ports of the bit and flag datapath.
`timescale 1ns/100ps
`default_nettype none
module bof_datapath_sva (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Register bus.
   input wire bof_pkg::bof_av_req_t av_req,
   input wire bof_pkg::bof_av_rsp_t av_rsp,
   // Core state.
   input wire logic [7:0] status_word,
   input wire logic [7:0] io_reg,
   input wire logic busy
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // A control write that the slave accepts launches one operation.
   wire logic go = av_req.write && !av_rsp.waitrequest &&
      av_req.address == bof_pkg::ADDR_CTRL;
   wire logic [4:0] op = av_req.writedata[4:0];
   wire logic [7:0] m = 8'h01 << av_req.writedata[10:8];
   a_read_wait_one: assert property ($rose(av_req.read) |->
      av_rsp.waitrequest ##1 !av_rsp.waitrequest) else $error("read late");
   a_idle_write_taken: assert property (av_req.write && !busy |->
      !av_rsp.waitrequest) else $error("idle write stalled");
   a_busy_stall: assert property (busy && av_req.write |->
      av_rsp.waitrequest) else $error("write taken while busy");
   a_base_no_busy: assert property (go && av_req.writedata[13:12] == 2'b00 |=>
      !busy) else $error("plain op stalled");
   a_sram_extra: assert property (go && av_req.writedata[12] |=>
      busy) else $error("sram op not stalled");
   a_io_set: assert property (go && op == bof_pkg::OP_IO_BIT_SET |=>
      io_reg == ($past(io_reg) | $past(m)) && $stable(status_word))
      else $error("io bit set");
   a_io_clear: assert property (go && op == bof_pkg::OP_IO_BIT_CLEAR |=>
      io_reg == ($past(io_reg) & ~$past(m)) && $stable(status_word))
      else $error("io bit clear");
   a_flag_set: assert property (go && op == bof_pkg::OP_FLAG_SET |=>
      status_word == ($past(status_word) | $past(m))) else $error("flag set");
   a_ovf_set: assert property (go && op == bof_pkg::OP_OVERFLOW_SET |=>
      status_word == ($past(status_word) | 8'h08)) else $error("v set");
   a_ovf_clear: assert property (go && op == bof_pkg::OP_OVERFLOW_CLEAR |=>
      status_word == ($past(status_word) & 8'hf7)) else $error("v clear");
   a_half_set: assert property (go && op == bof_pkg::OP_HALF_CARRY_SET |=>
      status_word == ($past(status_word) | 8'h20)) else $error("h set");
   a_half_clear: assert property (go && op == bof_pkg::OP_HALF_CARRY_CLEAR |=>
      status_word == ($past(status_word) & 8'hdf)) else $error("h clear");
   a_sign_set: assert property (go && op == bof_pkg::OP_SIGNED_SET |=>
      status_word == ($past(status_word) | 8'h10)) else $error("s set");
   a_sign_clear: assert property (go && op == bof_pkg::OP_SIGNED_CLEAR |=>
      status_word == ($past(status_word) & 8'hef)) else $error("s clear");
   a_quiet_ops: assert property (go && (op == bof_pkg::OP_SWAP ||
      op == bof_pkg::OP_TRANSFER_TO_BIT) |=> $stable(status_word))
      else $error("flags moved");
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the bit and flag datapath.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   bof_pkg::bof_av_req_t av_req = '0;
   bof_pkg::bof_av_rsp_t av_rsp;
   logic [7:0] status_word;
   logic [7:0] io_reg;
   logic busy;
   logic [31:0] seed = 32'ha0dc_8489;
   logic [31:0] q;
   logic [23:0] e;
   logic [7:0] d, w, io;
   logic [4:0] op;
   logic [2:0] s;
   logic [1:0] x;
   int mismatches = 0;
   int tests_run = 0;
   always #25 clk_sys = ~clk_sys;
   bof_datapath u_bof_datapath (.clk_sys(clk_sys), .rst(rst), .av_req(av_req),
      .av_rsp(av_rsp), .status_word(status_word), .io_reg(io_reg),
      .busy(busy));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Returns io, status and result; opcode numbers follow the package enum.
   function automatic logic [23:0] model(input logic [4:0] o,
      input logic [2:0] b, input logic [7:0] v, sw, pr);
      logic [7:0] r;
      logic f;
      r = v;
      f = 1'b0;
      case (o)
         5'h01: begin r = {v[6:0], sw[0]}; sw[0] = v[7]; sw[5] = v[3]; f = 1'b1; end
         5'h02: begin r = {sw[0], v[7:1]}; sw[0] = v[0]; f = 1'b1; end
         5'h03: begin r = {v[7], v[7:1]}; sw[0] = v[0]; f = 1'b1; end
         5'h04: r = {v[3:0], v[7:4]};
         5'h05: sw[b] = 1'b1;
         5'h06: sw[b] = 1'b0;
         5'h07: pr[b] = 1'b1;
         5'h08: pr[b] = 1'b0;
         5'h09: sw[6] = v[b];
         5'h0a: r[b] = sw[6];
         5'h0b: sw[3] = 1'b1;
         5'h0c: sw[3] = 1'b0;
         5'h0d: sw[5] = 1'b1;
         5'h0e: sw[5] = 1'b0;
         5'h0f: sw[4] = 1'b1;
         5'h10: sw[4] = 1'b0;
         default: r = v;
      endcase
      // Shifts share the flag update; sign is kept as negative xor overflow.
      if (f) begin
         sw[1] = (r == 8'h00);
         sw[2] = r[7];
         sw[3] = r[7] ^ sw[0];
         sw[4] = sw[2] ^ sw[3];
      end
      return {pr, sw, r};
   endfunction
   task automatic final_report();
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon transfer; waitrequest and readdata are taken at the edge.
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk_sys);
      av_req.address <= a;
      av_req.read <= rd;
      av_req.write <= !rd;
      av_req.writedata <= v;
      do begin
         @(posedge clk_sys);
         n++;
      end while (av_rsp.waitrequest !== 1'b0 && n < 100);
      if (av_rsp.waitrequest !== 1'b0) begin
         mismatches++;
         final_report();
      end
      q = av_rsp.readdata;
      av_req.read <= 1'b0;
      av_req.write <= 1'b0;
   endtask
   initial begin
      av_req.byteenable = 4'hf;
      repeat (6) @(posedge clk_sys);
      chk({15'h0, busy, io_reg, status_word}, 32'h0);
      rst <= 1'b0;
      bus(1'b1, bof_pkg::ADDR_STATUS, '0);
      chk(q, {24'h0, bof_pkg::SW_RESET});
      for (int i = 0; i < 64; i++) begin
         void'(rnd());
         op = 5'(i % 16 + 1);
         {x, s, io, w, d} = {seed[29:28], seed[26:24], seed[23:0]};
         if (i < 16) begin
            {x, w, d} = {2'b00, 8'h00, 8'h80};
         end
         bus(1'b0, bof_pkg::ADDR_OPERAND, {24'h0, d});
         bus(1'b0, bof_pkg::ADDR_STATUS, {24'h0, w});
         bus(1'b0, bof_pkg::ADDR_IO, {24'h0, io});
         bus(1'b0, bof_pkg::ADDR_CTRL, {18'h0, x, 1'b0, s, 3'h0, op});
         e = model(op, s, d, w, io);
         @(negedge clk_sys);
         chk({24'h0, status_word}, {24'h0, e[15:8]});
         bus(1'b1, bof_pkg::ADDR_STATUS, '0);
         chk(q, {24'h0, e[15:8]});
         bus(1'b1, bof_pkg::ADDR_RESULT, '0);
         chk(q, {24'h0, e[7:0]});
         bus(1'b1, bof_pkg::ADDR_OPERAND, '0);
         chk(q, {24'h0, e[7:0]});
         bus(1'b1, bof_pkg::ADDR_IO, '0);
         chk(q, {24'h0, e[23:16]});
         bus(1'b1, bof_pkg::ADDR_CYCLES, '0);
         chk(q, {30'h0, 2'h1 + x[0] + x[1]});
      end
      bus(1'b0, bof_pkg::ADDR_RESULT, 32'h0000_00a5);
      bus(1'b1, bof_pkg::ADDR_RESULT, '0);
      chk(q, {24'h0, e[7:0]});
      bus(1'b0, 8'h18, 32'h0000_00ff);
      bus(1'b1, 8'h18, '0);
      chk(q, bof_pkg::UNMAPPED_READ);
      final_report();
   end
endmodule
bind bof_datapath bof_datapath_sva u_bof_datapath_sva (.clk_sys(clk_sys),
   .rst(rst), .av_req(av_req), .av_rsp(av_rsp), .status_word(status_word),
   .io_reg(io_reg), .busy(busy));
`default_nettype wire
